//--- design/rwp_cfg.svh
/*
 * Constants of the router wait-policy and route-table block: configuration
 * map, register field positions, port numbering, character codes, timing.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef RWP_CFG_SVH
`define RWP_CFG_SVH

// ----------------------------------------------------------------------
// Configuration space
// ----------------------------------------------------------------------
`define RWP_PCS_HI      9'h01F
`define RWP_TBL_LO      9'h020
`define RWP_TBL_HI      9'h0FF
`define RWP_RCS_LO      9'h100
`define RWP_RCS_HI      9'h109

// ----------------------------------------------------------------------
// Register fields
// ----------------------------------------------------------------------
`define RWP_F_REQ_LSB   1
`define RWP_F_REQ_MSB   10
`define RWP_F_STRIP     29
`define RWP_F_PRIO      30
`define RWP_F_INV       31
`define RWP_RC_WDOG     0
`define RWP_RC_SOR      1
`define RWP_PS_ADDR_ERR 0
`define RWP_PT_CFG      3'h0
`define RWP_PT_SPW      3'h1
`define RWP_PT_EXT      3'h2
`define RWP_NO_CONN     5'h1F

// ----------------------------------------------------------------------
// Ports and characters
// ----------------------------------------------------------------------
`define RWP_NPORT       11
`define RWP_LAST_SPW    5'h08
`define RWP_LAST_PORT   5'h0A
`define RWP_IN_PORT     5'h01
`define RWP_SPW_MASK    11'h1FE
`define RWP_LOG_LO      8'h20
`define RWP_CH_EOP      9'h100
`define RWP_CH_EEP      9'h101

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RWP_CLK_NS      100
`define RWP_TIMEOUT_NS  100000
`define RWP_TMO_CYC     (`RWP_TIMEOUT_NS / `RWP_CLK_NS)

`endif

//--- design/rwp_pkg.sv
/*
 * Types of the router wait-policy and route-table block.
 * Assumes rwp_cfg.svh is on the include path.
 */
`default_nettype none
`include "rwp_cfg.svh"

package rwp_pkg;

	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_LOOK  = 3'h1,
		S_WAIT  = 3'h3,
		S_FWD   = 3'h2,
		S_TERM  = 3'h6,
		S_SPILL = 3'h7
	} rwp_st_t;

	typedef struct packed {
		rwp_st_t     st;
		logic [10:0] tmr;
		logic [7:0]  hdr;
		logic        hdr_pend;
		logic        strip;
		logic [10:0] req;
		logic        prio;
		logic [10:0] oreq;
		logic [10:0] conn;
		logic [10:0] start_req;
		logic        tx_valid;
		logic [8:0]  tx_data;
		logic [10:0] tx_dest;
		logic        cfg_ack;
		logic [31:0] cfg_rdata;
		logic        wd_en;
		logic        sor_en;
		logic        addr_err;
	} rwp_core_t;

	typedef struct packed {
		logic       rst_m;
		logic       rst_s;
		logic [8:0] hold;
		logic       req_t;
		logic       ack_m;
		logic       ack_s;
		logic       rdy;
	} rwp_lnk_t;

	typedef struct packed {
		logic req_m;
		logic req_s;
		logic ack_t;
	} rwp_ref_t;

endpackage

`default_nettype wire

//--- design/rwp_char_cdc.sv
/*
 * Character crossing from the link clock into the router clock by a
 * toggle handshake; one character in flight at a time.
 * Assumes the link clock runs while characters arrive.
 */
`default_nettype none
`include "rwp_cfg.svh"

module rwp_char_cdc
	import rwp_pkg::*;
(
	input  wire logic       lnk_clk,
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       rx_valid,
	input  wire logic [8:0] rx_data,
	output logic            rx_ready,
	output logic            ch_valid,
	output logic [8:0]      ch_data,
	input  wire logic       ch_pop
);

	rwp_lnk_t l_q, l_d;
	rwp_ref_t r_q, r_d;

	// ----------------------------------------------------------------------
	// Link side
	// ----------------------------------------------------------------------
	// The held character stays still until the far side toggles back, so
	// the word needs no synchroniser of its own.
	always_comb begin
		l_d = l_q;
		l_d.rst_m = sys_rst;
		l_d.rst_s = l_q.rst_m;
		l_d.ack_m = r_q.ack_t;
		l_d.ack_s = l_q.ack_m;
		l_d.rdy = (l_q.req_t == l_q.ack_s);
		if (rx_valid & l_q.rdy) begin
			l_d.hold = rx_data;
			l_d.req_t = ~l_q.req_t;
			l_d.rdy = 1'b0;
		end
		if (l_q.rst_s) begin
			l_d.hold = 9'h000;
			l_d.req_t = 1'b0;
			l_d.ack_m = 1'b0;
			l_d.ack_s = 1'b0;
			l_d.rdy = 1'b0;
		end
	end

	always_ff @(posedge lnk_clk) begin
		l_q <= l_d;
	end

	// ----------------------------------------------------------------------
	// Router side
	// ----------------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.req_m = l_q.req_t;
		r_d.req_s = r_q.req_m;
		if (ch_pop)
			r_d.ack_t = ~r_q.ack_t;
		if (sys_rst)
			r_d = '0;
	end

	always_ff @(posedge ref_clk) begin
		r_q <= r_d;
	end

	assign rx_ready = l_q.rdy;
	assign ch_valid = (r_q.req_s != r_q.ack_t);
	assign ch_data = l_q.hold;

endmodule

`default_nettype wire

//--- design/rwp_router_core.sv
/*
 * One router input port with its forwarding policy (blocking-allowed and
 * watchdog modes, single and group destinations, spilling), the logical
 * address route table and the configuration register decode.
 * Assumes an outside crossbar reports port running/busy state and the
 * contending input's requests on ref_clk, and takes characters by tx_ready.
 */
`default_nettype none
`include "rwp_cfg.svh"

module rwp_router_core
	import rwp_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        lnk_clk,
	input  wire logic        rx_valid,
	input  wire logic [8:0]  rx_data,
	output logic             rx_ready,
	input  wire logic        cfg_req,
	input  wire logic        cfg_we,
	input  wire logic [8:0]  cfg_addr,
	input  wire logic [31:0] cfg_wdata,
	output logic             cfg_ack,
	output logic [31:0]      cfg_rdata,
	input  wire logic [10:0] port_running,
	input  wire logic [10:0] port_busy,
	input  wire logic [10:0] other_req,
	input  wire logic        other_prio,
	output logic [10:0]      out_req,
	output logic             out_prio,
	output logic [10:0]      start_req,
	output logic             tx_valid,
	output logic [8:0]       tx_data,
	output logic [10:0]      tx_dest,
	input  wire logic        tx_ready
);

	rwp_core_t   s_q, s_d;
	logic [11:0] tbl [32:255];
	logic [255:32] inv_q;
	logic        ch_valid;
	logic [8:0]  ch_data;
	logic        ch_pop;
	logic [11:0] ent;
	logic        ent_inv;
	logic [10:0] lost;
	logic [10:0] avail;
	logic        run_any;
	logic        tx_free;
	logic        moved;
	logic        expire;
	logic        tbl_we;
	logic        tbl_zero;

	// ----------------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------------
	function automatic logic is_ctrl(input logic [8:0] c);
		is_ctrl = c[8];
	endfunction

	function automatic logic [10:0] lowest(input logic [10:0] v);
		lowest = v & (~v + 11'h001);
	endfunction

	function automatic logic [2:0] ptype(input logic [4:0] p);
		if (p == 5'h00)
			ptype = `RWP_PT_CFG;
		else if (p <= `RWP_LAST_SPW)
			ptype = `RWP_PT_SPW;
		else
			ptype = `RWP_PT_EXT;
	endfunction

	function automatic logic [31:0] rd_word(input logic [8:0] a);
		logic [31:0] w;
		logic [4:0]  pn;
		w = 32'h0000_0000;
		pn = a[4:0];
		if (a <= `RWP_PCS_HI) begin
			if (pn <= `RWP_LAST_PORT) begin
				w[31:29] = ptype(pn);
				w[28:24] = s_q.conn[pn[3:0]] ? `RWP_IN_PORT : `RWP_NO_CONN;
				if (pn == `RWP_IN_PORT)
					w[`RWP_PS_ADDR_ERR] = s_q.addr_err;
			end
		end else if (a <= `RWP_TBL_HI) begin
			w[`RWP_F_INV] = inv_q[a[7:0]];
			w[`RWP_F_PRIO] = tbl[a[7:0]][11];
			w[`RWP_F_STRIP] = tbl[a[7:0]][10];
			w[`RWP_F_REQ_MSB:`RWP_F_REQ_LSB] = tbl[a[7:0]][9:0];
		end else if (a == `RWP_RCS_LO) begin
			w[`RWP_RC_WDOG] = s_q.wd_en;
			w[`RWP_RC_SOR] = s_q.sor_en;
		end
		rd_word = w;
	endfunction

	// ----------------------------------------------------------------------
	// Link character crossing
	// ----------------------------------------------------------------------
	rwp_char_cdc u_cdc (
		.lnk_clk  (lnk_clk),
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.rx_valid (rx_valid),
		.rx_data  (rx_data),
		.rx_ready (rx_ready),
		.ch_valid (ch_valid),
		.ch_data  (ch_data),
		.ch_pop   (ch_pop)
	);

	// ----------------------------------------------------------------------
	// Route table
	// ----------------------------------------------------------------------
	// Request, strip and priority fields hold their contents across reset;
	// only the invalid flags are forced, so an unset address never routes.
	assign tbl_we = cfg_req & cfg_we & (cfg_addr >= `RWP_TBL_LO)
		& (cfg_addr <= `RWP_TBL_HI);
	assign tbl_zero = (cfg_wdata[`RWP_F_REQ_MSB:`RWP_F_REQ_LSB] == 10'h000);

	always_ff @(posedge ref_clk) begin
		if (tbl_we) begin
			if (tbl_zero)
				tbl[cfg_addr[7:0]] <= 12'h000;
			else
				tbl[cfg_addr[7:0]] <= {cfg_wdata[`RWP_F_PRIO],
					cfg_wdata[`RWP_F_STRIP],
					cfg_wdata[`RWP_F_REQ_MSB:`RWP_F_REQ_LSB]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			inv_q <= '1;
		else if (tbl_we)
			inv_q[cfg_addr[7:0]] <= tbl_zero | cfg_wdata[`RWP_F_INV];
	end

	assign ent = (s_q.hdr >= `RWP_LOG_LO) ? tbl[s_q.hdr] : 12'h000;
	assign ent_inv = (s_q.hdr >= `RWP_LOG_LO) ? inv_q[s_q.hdr] : 1'b0;

	// ----------------------------------------------------------------------
	// Wait decisions
	// ----------------------------------------------------------------------
	// Ties go to the other input, which keeps the grant deterministic.
	assign lost = other_req & {11{other_prio | ~s_q.prio}};
	assign avail = s_q.req & port_running & ~port_busy & ~lost;
	assign run_any = |(s_q.req & port_running);
	assign tx_free = ~s_q.tx_valid | tx_ready;
	assign moved = tx_free & (s_q.hdr_pend | ch_valid);
	assign expire = (s_q.tmr == 11'(`RWP_TMO_CYC - 1));

	always_comb begin
		s_d = s_q;
		ch_pop = 1'b0;
		s_d.cfg_ack = cfg_req;
		if (cfg_req)
			s_d.cfg_rdata = rd_word(cfg_addr);
		if (cfg_req & cfg_we & (cfg_addr == `RWP_RCS_LO)) begin
			s_d.wd_en = cfg_wdata[`RWP_RC_WDOG];
			s_d.sor_en = cfg_wdata[`RWP_RC_SOR];
		end
		if (cfg_req & cfg_we & (cfg_addr == {4'h0, `RWP_IN_PORT}))
			s_d.addr_err = 1'b0;
		if (s_q.tx_valid & tx_ready)
			s_d.tx_valid = 1'b0;
		case (s_q.st)
		S_IDLE: begin
			s_d.tmr = 11'h000;
			if (ch_valid) begin
				ch_pop = 1'b1;
				if (!is_ctrl(ch_data)) begin
					s_d.hdr = ch_data[7:0];
					s_d.st = S_LOOK;
				end
			end
		end
		S_LOOK: begin
			s_d.tmr = 11'h000;
			if (s_q.hdr < `RWP_LOG_LO) begin
				if (s_q.hdr <= {3'h0, `RWP_LAST_PORT}) begin
					s_d.req = 11'h001 << s_q.hdr[3:0];
					s_d.strip = 1'b1;
					s_d.prio = 1'b0;
					s_d.hdr_pend = 1'b0;
					s_d.st = S_WAIT;
				end else begin
					s_d.addr_err = 1'b1;
					s_d.st = S_SPILL;
				end
			end else if (ent_inv) begin
				s_d.addr_err = 1'b1;
				s_d.st = S_SPILL;
			end else begin
				s_d.req = {ent[9:0], 1'b0};
				s_d.strip = ent[10];
				s_d.prio = ent[11];
				s_d.hdr_pend = ~ent[10];
				s_d.st = S_WAIT;
			end
		end
		S_WAIT: begin
			s_d.start_req = s_q.sor_en ? (s_q.req & ~port_running)
				: 11'h000;
			if (|avail) begin
				s_d.conn = lowest(avail);
				s_d.start_req = 11'h000;
				s_d.tmr = 11'h000;
				s_d.st = S_FWD;
			end else if (run_any) begin
				s_d.tmr = 11'h000;
			end else if (s_q.wd_en | (|(s_q.req & `RWP_SPW_MASK))) begin
				s_d.tmr = expire ? 11'h000
					: s_q.tmr + 11'h001;
				if (expire) begin
					s_d.start_req = 11'h000;
					s_d.st = S_SPILL;
				end
			end
		end
		S_FWD: begin
			if (moved) begin
				s_d.tmr = 11'h000;
				s_d.tx_valid = 1'b1;
				s_d.tx_dest = s_q.conn;
				if (s_q.hdr_pend) begin
					s_d.tx_data = {1'b0, s_q.hdr};
					s_d.hdr_pend = 1'b0;
				end else begin
					ch_pop = 1'b1;
					s_d.tx_data = ch_data;
					if (is_ctrl(ch_data)) begin
						s_d.conn = 11'h000;
						s_d.st = S_IDLE;
					end
				end
			end else if (s_q.wd_en) begin
				s_d.tmr = expire ? 11'h000
					: s_q.tmr + 11'h001;
				if (expire)
					s_d.st = S_TERM;
			end
		end
		S_TERM: begin
			// The error end waits for room at the output before the path
			// is released.
			if (tx_free) begin
				s_d.tx_valid = 1'b1;
				s_d.tx_data = `RWP_CH_EEP;
				s_d.tx_dest = s_q.conn;
				s_d.conn = 11'h000;
				s_d.st = S_SPILL;
			end
		end
		S_SPILL: begin
			s_d.tmr = 11'h000;
			if (ch_valid) begin
				ch_pop = 1'b1;
				if (is_ctrl(ch_data))
					s_d.st = S_IDLE;
			end
		end
		default: begin
			s_d.st = S_IDLE;
		end
		endcase
		s_d.oreq = (s_d.st == S_WAIT) ? s_d.req : 11'h000;
		if (sys_rst)
			s_d = '0;
	end

	always_ff @(posedge ref_clk) begin
		s_q <= s_d;
	end

	assign cfg_ack = s_q.cfg_ack;
	assign cfg_rdata = s_q.cfg_rdata;
	assign out_req = s_q.oreq;
	assign out_prio = s_q.prio;
	assign start_req = s_q.start_req;
	assign tx_valid = s_q.tx_valid;
	assign tx_data = s_q.tx_data;
	assign tx_dest = s_q.tx_dest;

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	AST_CONNECT_IDLE_PORT: assert property (
		s_q.st == S_WAIT && |avail |=>
		s_q.st == S_FWD && s_q.conn == lowest($past(avail)))
		else $error("idle running port not connected");
	AST_RUNNING_WAITS: assert property (
		s_q.st == S_WAIT && run_any && !(|avail) |=>
		s_q.st == S_WAIT && s_q.tmr == 11'h000)
		else $error("wait for running port was limited");
	AST_TIMER_BOUND: assert property (
		s_q.tmr < 11'(`RWP_TMO_CYC))
		else $error("wait timer passed the timeout");
	AST_WAIT_EXPIRY: assert property (
		s_q.st == S_WAIT && s_q.wd_en && !run_any && expire |=>
		s_q.st == S_SPILL && s_q.start_req == 11'h000)
		else $error("expired wait did not discard");
	AST_EEP_APPEND: assert property (
		s_q.st == S_TERM && tx_free |=>
		s_q.tx_valid && s_q.tx_data == `RWP_CH_EEP && s_q.st == S_SPILL)
		else $error("error end not appended on expiry");
	AST_STALL_HOLDS: assert property (
		s_q.st == S_FWD && !s_q.wd_en && !moved [*2] |=>
		s_q.st == S_FWD && s_q.conn == $past(s_q.conn, 2))
		else $error("blocking mode released a stalled path");
	AST_UNSTARTED_SPW: assert property (
		s_q.st == S_WAIT && !s_q.wd_en && !run_any && !(|avail)
		&& !(|(s_q.req & `RWP_SPW_MASK)) |=> s_q.tmr == 11'h000)
		else $error("blocking mode timed a non SpaceWire wait");
	AST_INVALID_DROP: assert property (
		s_q.st == S_LOOK && s_q.hdr >= `RWP_LOG_LO && ent_inv |=>
		s_q.st == S_SPILL && s_q.addr_err)
		else $error("invalid address not discarded");
	AST_ZERO_WRITE: assert property (
		tbl_we && tbl_zero |=>
		inv_q[$past(cfg_addr[7:0])] && tbl[$past(cfg_addr[7:0])] == 12'h000)
		else $error("zero request write did not invalidate");
	AST_MODE_BIT: assert property (
		cfg_req && cfg_we && cfg_addr == `RWP_RCS_LO |=>
		s_q.wd_en == $past(cfg_wdata[`RWP_RC_WDOG]))
		else $error("mode bit not taken");
	AST_NO_PORT0: assert property (
		s_q.st == S_LOOK && s_q.hdr >= `RWP_LOG_LO |=> !s_q.req[0])
		else $error("logical address reached port 0");
	AST_STRIP: assert property (
		s_q.st == S_LOOK && s_q.hdr >= `RWP_LOG_LO && !ent_inv |=>
		s_q.hdr_pend == !$past(ent[10]))
		else $error("header strip flag ignored");

	COV_FORWARD: cover property (s_q.st == S_WAIT ##1 s_q.st == S_FWD);
	COV_WAIT_SPILL: cover property (s_q.st == S_WAIT ##1 s_q.st == S_SPILL);
	COV_TERM: cover property (s_q.st == S_TERM ##1 s_q.st == S_SPILL);

endmodule

`default_nettype wire

//--- testbench/rwp_link_src.sv
/*
 * Far-end link source of the router input port: sends queued characters
 * by the valid/ready handshake and gates its own link clock off between
 * frames. Assumes the bench fills q and supplies a free 30 ns clock.
 */
`default_nettype none

module rwp_link_src (
	input  wire logic  lnk_free,
	input  wire logic  sys_rst,
	output logic       lnk_clk,
	output logic       rx_valid,
	output logic [8:0] rx_data,
	input  wire logic  rx_ready
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [8:0] q[$];
	logic       en = 1'b1;

	// Enable is taken while the clock is low so the gated clock has no
	// runt pulse; it keeps running until the port's ready has come back.
	always @(negedge lnk_free) begin
		en <= sys_rst | ~rx_ready | rx_valid | (q.size() != 0);
	end
	assign lnk_clk = lnk_free & en;

	always @(posedge lnk_clk) begin
		if (sys_rst) begin
			rx_valid <= 1'b0;
			rx_data <= 9'h000;
		end else if (rx_valid && rx_ready) begin
			rx_valid <= 1'b0;
			rx_data <= ~rx_data;
		end else if (!rx_valid && q.size() != 0) begin
			rx_valid <= 1'b1;
			rx_data <= q.pop_front();
		end
	end
endmodule

`default_nettype wire

//--- testbench/tb_top.sv
/*
 * Self-checking bench of the router input port: configuration map,
 * forwarding, header strip, address errors, waits and watchdog spill.
 * Assumes the design files and rwp_link_src are compiled before it.
 */
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic        ref_clk = 1'b0;
	logic        lnk_free = 1'b0;
	logic        sys_rst = 1'b1;
	logic        lnk_clk, rx_valid, rx_ready, cfg_ack, tx_valid, out_prio;
	logic [8:0]  rx_data, tx_data;
	logic        cfg_req = 1'b0;
	logic        cfg_we = 1'b0;
	logic        other_prio = 1'b0;
	logic        tx_ready = 1'b1;
	logic        slow = 1'b0;
	logic [8:0]  cfg_addr = 9'h000;
	logic [31:0] cfg_wdata = 32'h0;
	logic [31:0] cfg_rdata, rd, rnd;
	logic [10:0] port_running = 11'h00C;
	logic [10:0] port_busy = 11'h000;
	logic [10:0] other_req = 11'h000;
	logic [10:0] out_req, start_req, tx_dest;
	logic [19:0] exp_q[$];
	integer      seed = 75083;
	integer      mismatches = 0;
	integer      check_count = 0;
	integer      cyc = 0;
	logic [8:0]  pa [8] = '{9'h000, 9'h001, 9'h008, 9'h009, 9'h00A,
		9'h00B, 9'h101, 9'h10A};
	logic [31:0] pe [8] = '{32'h1F000000, 32'h3F000000, 32'h3F000000,
		32'h5F000000, 32'h5F000000, 32'h0, 32'h0, 32'h0};

	always #50 ref_clk = ~ref_clk;
	initial begin
		#7;
		forever #15 lnk_free = ~lnk_free;
	end

	rwp_router_core DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.lnk_clk(lnk_clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready), .cfg_req(cfg_req), .cfg_we(cfg_we),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
		.cfg_rdata(cfg_rdata), .port_running(port_running),
		.port_busy(port_busy), .other_req(other_req),
		.other_prio(other_prio), .out_req(out_req), .out_prio(out_prio),
		.start_req(start_req), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_dest(tx_dest), .tx_ready(tx_ready));

	rwp_link_src SRC (.lnk_free(lnk_free), .sys_rst(sys_rst),
		.lnk_clk(lnk_clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready));

	// ------------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic cfg(input logic w, input logic [8:0] a,
		input logic [31:0] d);
		@(negedge ref_clk);
		cfg_req = 1'b1;
		cfg_we = w;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge ref_clk);
		cfg_req = 1'b0;
		check({31'h0, cfg_ack}, 32'h1);
		rd = cfg_rdata;
	endtask

	task automatic rdchk(input logic [8:0] a, input logic [31:0] e);
		cfg(1'b0, a, 32'h0);
		check(rd, e);
	endtask

	task automatic ch(input logic [8:0] c, input logic [10:0] d,
		input logic keep);
		SRC.q.push_back(c);
		if (keep)
			exp_q.push_back({d, c});
	endtask

	task automatic pkt(input logic [8:0] h, input logic [10:0] d = 11'h004);
		ch(h, d, 1'b1);
		ch({1'b0, rnd[8:1]}, d, 1'b1);
		ch(9'h100, d, 1'b1);
	endtask

	// Waits for the source to empty and the expected output to appear.
	task automatic drain(input int n);
		int i;
		for (i = 0; i < n && (exp_q.size() != 0 || SRC.q.size() != 0
			|| rx_valid); i++)
			@(negedge ref_clk);
		repeat (30) @(negedge ref_clk);
		check(exp_q.size(), 0);
	endtask

	// ------------------------------------------------------------------
	// Output sink, monitor and time limit
	// ------------------------------------------------------------------
	always @(posedge ref_clk) rnd <= $random(seed);
	always @(negedge ref_clk) tx_ready <= slow ? rnd[0] : 1'b1;

	always @(posedge ref_clk) begin
		if (!sys_rst && tx_valid === 1'b1 && tx_ready) begin
			if (exp_q.size() == 0)
				check({tx_dest, tx_data}, 32'hFFFFFFFF);
			else
				check({tx_dest, tx_data}, exp_q.pop_front());
		end
	end

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			conclude();
		end
	end

	initial begin
		repeat (16) @(negedge ref_clk);
		sys_rst = 1'b0;
		cfg(1'b0, 9'h027, 32'h0);
		check({31'h0, rd[31]}, 32'h1);
		cfg(1'b1, 9'h027, 32'hFFFFFFFF);
		rdchk(9'h027, 32'hE00007FE);
		cfg(1'b1, 9'h027, 32'h40000001);
		rdchk(9'h027, 32'h80000000);
		cfg(1'b1, 9'h100, 32'hFFFFFFFF);
		rdchk(9'h100, 32'h00000003);
		cfg(1'b1, 9'h100, 32'h00000000);
		for (int i = 0; i < 8; i++)
			rdchk(pa[i], pe[i]);
		cfg(1'b1, 9'h027, 32'h00000004);
		cfg(1'b1, 9'h028, 32'h20000008);
		cfg(1'b1, 9'h029, 32'h00000002);
		rdchk(9'h028, 32'h20000008);
		slow = 1'b1;
		pkt(9'h027);
		drain(300);
		ch(9'h028, 11'h000, 1'b0);
		ch(9'h011, 11'h008, 1'b1);
		ch(9'h100, 11'h008, 1'b1);
		drain(300);
		ch(9'h002, 11'h000, 1'b0);
		ch(9'h033, 11'h004, 1'b1);
		ch(9'h100, 11'h004, 1'b1);
		drain(300);
		ch(9'h030, 11'h000, 1'b0);
		ch(9'h044, 11'h000, 1'b0);
		ch(9'h100, 11'h000, 1'b0);
		drain(300);
		rdchk(9'h001, 32'h3F000001);
		cfg(1'b1, 9'h001, 32'h0);
		rdchk(9'h001, 32'h3F000000);
		slow = 1'b0;
		ch(9'h029, 11'h000, 1'b0);
		ch(9'h055, 11'h000, 1'b0);
		ch(9'h100, 11'h000, 1'b0);
		repeat (950) @(negedge ref_clk);
		check(out_req, 11'h002);
		drain(400);
		check(out_req, 11'h000);
		cfg(1'b1, 9'h02A, 32'h00000200);
		pkt(9'h02A, 11'h200);
		repeat (1200) @(negedge ref_clk);
		check(out_req, 11'h200);
		port_running = 11'h20C;
		drain(300);
		port_running = 11'h00C;
		port_busy = 11'h004;
		pkt(9'h027);
		repeat (1200) @(negedge ref_clk);
		check(exp_q.size(), 3);
		port_busy = 11'h000;
		drain(300);
		other_req = 11'h004;
		other_prio = 1'b1;
		pkt(9'h027);
		repeat (60) @(negedge ref_clk);
		check(exp_q.size(), 3);
		check(out_req, 11'h004);
		check({31'h0, out_prio}, 32'h0);
		other_req = 11'h000;
		drain(300);
		cfg(1'b1, 9'h027, 32'h40000004);
		other_req = 11'h004;
		other_prio = 1'b0;
		pkt(9'h027);
		drain(300);
		check({31'h0, out_prio}, 32'h1);
		other_req = 11'h000;
		cfg(1'b1, 9'h100, 32'h00000001);
		ch(9'h027, 11'h004, 1'b1);
		ch(9'h066, 11'h004, 1'b1);
		exp_q.push_back({11'h004, 9'h101});
		drain(1500);
		ch(9'h077, 11'h000, 1'b0);
		ch(9'h100, 11'h000, 1'b0);
		drain(300);
		port_busy = 11'h004;
		pkt(9'h027);
		repeat (1200) @(negedge ref_clk);
		check(exp_q.size(), 3);
		port_busy = 11'h000;
		drain(300);
		cfg(1'b1, 9'h100, 32'h00000003);
		cfg(1'b1, 9'h02A, 32'h00000012);
		pkt(9'h02A, 11'h010);
		repeat (60) @(negedge ref_clk);
		check(start_req, 11'h012);
		check(out_req, 11'h012);
		port_running = 11'h01C;
		drain(300);
		check(start_req, 11'h000);
		conclude();
	end
endmodule

`default_nettype wire
